// ---- dv/lkt_bus_model.sv ----
// far side of the bus: other nodes and the master pull-up
// assumes the block drives the line open-drain through bus_oe
`timescale 1ns/10ps
`default_nettype none
module lkt_bus_model
(
	input  wire logic bus_oe,   // block pulls the line dominant
	input  wire logic bus_out,  // block drive level
	input  wire logic node_dom, // another node or a short holds the line low
	output logic      bus_line  // resolved wire level
);
	// wired-and: a released line returns to the pull-up level, never the last value
	assign bus_line = (bus_oe ? bus_out : 1'b1) & ~node_dom;
endmodule
`default_nettype wire

// ---- dv/lkt_ctrl_test.sv ----
// self-checking bench of the transceiver control block
// assumes lkt_pkg compiled first and lkt_cfg.svh on the include path
`timescale 1ns/10ps
`default_nettype none
module lkt_ctrl_test;
	import lkt_pkg::*;
	logic     mclk, nrst, tx_in, rx_out, bus_in, bus_out, bus_oe, cfg_wr;
	logic     diag_clr, bus_overtemp_flag, overtemp, supply_ok, tx_timeout, node_dom;
	lkt_cfg_t cfg_wdata, cfg_rdata; // config write and readback
	lkt_drv_t drv_ctrl;             // analog stage controls
	int       n_errors, samples_checked;

	lkt_ctrl DUT (.mclk(mclk), .nrst(nrst), .tx_in(tx_in), .rx_out(rx_out), .bus_in(bus_in),
		.bus_out(bus_out), .bus_oe(bus_oe), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata),
		.cfg_rdata(cfg_rdata), .diag_clr(diag_clr), .bus_overtemp_flag(bus_overtemp_flag),
		.overtemp(overtemp), .supply_ok(supply_ok), .drv_ctrl(drv_ctrl), .tx_timeout(tx_timeout));
	lkt_bus_model bus (.bus_oe(bus_oe), .bus_out(bus_out), .node_dom(node_dom), .bus_line(bus_in));

	// 20 MHz clock
	initial
	begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	// wait n edges, then the fixed drive delay
	task automatic step(input int n);
		repeat (n) @(posedge mclk);
		#5;
	endtask

	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// one-cycle config strobe
	task automatic write_cfg(input logic toe, input logic [1:0] m);
		cfg_wdata.tx_timeout_enable = toe;
		cfg_wdata.mode = lkt_mode_t'(m);
		cfg_wr = 1'b1;
		step(1);
		cfg_wr = 1'b0;
	endtask

	task automatic t_reset();
		check("cfg", cfg_rdata, 8'h04);
		check("drv", drv_ctrl, 8'h07);
		check("oe", bus_oe, 8'h00);
		check("rx", rx_out, 8'h01);
		check("flag", bus_overtemp_flag, 8'h00);
		$display("test reset done");
	endtask

	// dominant bit out and echoed back, three edges each way
	task automatic t_tx_rx();
		tx_in = 1'b0;
		step(2);
		check("oe", bus_oe, 8'h00);
		step(1);
		check("oe", bus_oe, 8'h01);
		check("out", bus_out, 8'h00);
		step(3);
		check("rx", rx_out, 8'h00);
		tx_in = 1'b1; // bit times far below the time-out keep the rate legal
		step(3);
		check("oe", bus_oe, 8'h00);
		step(3);
		check("rx", rx_out, 8'h01);
		$display("test tx_rx done");
	endtask

	// every mode code, including the unused one that falls back to normal
	task automatic t_modes();
		logic [1:0] codes [4];
		logic [2:0] exp_rd [4];
		logic [2:0] exp_drv [4];
		codes = '{2'h0, 2'h1, 2'h3, 2'h2};
		exp_rd = '{3'h4, 3'h5, 3'h7, 3'h4};
		// enable, slope, limit; the stage controls trail the config by one edge
		exp_drv = '{3'h7, 3'h3, 3'h4, 3'h7};
		for (int i = 0; i < 4; i++)
		begin
			write_cfg(1'b1, codes[i]);
			check("cfg", cfg_rdata, exp_rd[i]);
			tx_in = 1'b0;
			step(4);
			check("oe", bus_oe, (codes[i] == 2'h1) ? 8'h00 : 8'h01);
			check("drv", drv_ctrl, exp_drv[i]);
			if (codes[i] != 2'h1)
				check("slope", {drv_ctrl.slope_ctrl, drv_ctrl.current_limit},
					(codes[i] == 2'h3) ? 8'h00 : 8'h03);
			node_dom = 1'b1;
			step(4);
			check("rx", rx_out, 8'h00);
			node_dom = 1'b0;
			tx_in = 1'b1;
			step(4);
		end
		write_cfg(1'b1, 2'h0);
		$display("test modes done");
	endtask

	// sticky flag, set beats clear, config untouched
	task automatic t_overtemp();
		tx_in = 1'b0;
		overtemp = 1'b1;
		step(4);
		check("oe", bus_oe, 8'h00);
		check("flag", bus_overtemp_flag, 8'h01);
		check("drv", drv_ctrl, 8'h03);
		check("cfg", cfg_rdata, 8'h04);
		diag_clr = 1'b1;
		step(1);
		diag_clr = 1'b0;
		step(1);
		check("flag", bus_overtemp_flag, 8'h01);
		overtemp = 1'b0;
		step(3);
		check("oe", bus_oe, 8'h01);
		diag_clr = 1'b1;
		step(1);
		diag_clr = 1'b0;
		step(1);
		check("flag", bus_overtemp_flag, 8'h00);
		tx_in = 1'b1;
		step(4);
		$display("test overtemp done");
	endtask

	// bad supply, then a shorted line, each recovering without bus traffic
	task automatic t_faults();
		supply_ok = 1'b0;
		step(4);
		check("oe", bus_oe, 8'h00);
		check("rx", rx_out, 8'h01);
		supply_ok = 1'b1;
		node_dom = 1'b1;
		step(200);
		check("rx", rx_out, 8'h00);
		node_dom = 1'b0;
		step(3);
		check("rx", rx_out, 8'h01);
		tx_in = 1'b0;
		step(3);
		check("oe", bus_oe, 8'h01);
		tx_in = 1'b1;
		step(4);
		$display("test faults done");
	endtask

	// disabled time-out: a long dominant run keeps driving
	// the full 12 ms expiry is too long for this run and rests on the in-design checks
	task automatic t_toe_off();
		write_cfg(1'b0, 2'h0);
		tx_in = 1'b0;
		step(3000);
		check("oe", bus_oe, 8'h01);
		check("to", tx_timeout, 8'h00);
		check("cnt_idle", DUT.to_cnt == '0, 8'h01);
		tx_in = 1'b1;
		step(4);
		write_cfg(1'b1, 2'h0);
		// enabled run: counter must be running yet far below the 6 ms floor
		tx_in = 1'b0;
		step(3000);
		check("to", tx_timeout, 8'h00);
		check("oe", bus_oe, 8'h01);
		check("cnt_run", DUT.to_cnt > 18'd2900, 8'h01);
		tx_in = 1'b1;
		step(4);
		check("cnt_clr", DUT.to_cnt == '0, 8'h01);
		$display("test toe_off done");
	endtask

	task automatic complete_run();
		$display("errors %0d checks %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// watchdog sized well above the few thousand cycles the tests need
	initial
	begin
		#(20000 * 50);
		n_errors++;
		complete_run();
	end

	initial
	begin
		n_errors = 0;
		samples_checked = 0;
		nrst = 1'b0;
		tx_in = 1'b1;
		cfg_wr = 1'b0;
		cfg_wdata = 3'h4;
		diag_clr = 1'b0;
		overtemp = 1'b0;
		supply_ok = 1'b1;
		node_dom = 1'b0;
		step(2);
		nrst = 1'b1;
		step(1);
		t_reset();
		t_tx_rx();
		t_modes();
		t_overtemp();
		t_faults();
		t_toe_off();
		complete_run();
	end
endmodule
`default_nettype wire

// ---- hw/lkt_cfg.svh ----
// constants for the single-wire bus transceiver control block
// assumes a 20 MHz mclk and the mode encodings of lkt_pkg
`ifndef LKT_CFG_SVH
`define LKT_CFG_SVH
`define LKT_CLK_HZ          20000000
`define LKT_TO_MIN_MS       6
`define LKT_TO_TYP_MS       12
`define LKT_TO_MAX_MS       20
`define LKT_TO_CYCLES       ((`LKT_TO_TYP_MS * `LKT_CLK_HZ) / 1000)
`define LKT_TO_CNT_W        18
`define LKT_NORMAL_KBPS     20
`define LKT_FLASH_KBPS      115
`define LKT_MIN_TX_BPS      1600
`define LKT_MODE_W          2
`define LKT_MODE_RST        2'h0
`define LKT_TOE_RST         1'b1
`define LKT_MODE_POS        0
`define LKT_TOE_POS         2
`endif

// ---- hw/lkt_ctrl.sv ----
// digital control of the single-wire bus transceiver, slave side
// assumes config writes arrive as one-cycle strobes from the serial command decoder on mclk
//
// Behaviour
// - transmit input drives bus, low is dominant
// - receive output mirrors bus while receiver active
// - mode taken from written configuration field
// - reset value of mode field selects mode
// - normal mode keeps slope control, current limit
// - receive-only never drives bus
// - flash mode drops slope control, current limit
// - long dominant transmit disables output stage
// - time-out between 6 and 20 ms
// - rising transmit edge re-arms transmission
// - enable bit can suppress the time-out
// - overtemperature kills driver, sets sticky flag
// - bad supply never drives dominant on recessive
// - bad supply, recessive bus keeps receive high
// - supply return resumes without bus activity
// - short removal resumes without bus activity
// - bus activity never causes a wake event
// - k-line uses normal mode, same failure handling
`timescale 1ns/10ps
`default_nettype none
`include "lkt_cfg.svh"
module lkt_ctrl
	import lkt_pkg::*;
(
	input  wire logic     mclk,              // 20 MHz system clock
	input  wire logic     nrst,              // synchronous reset, active low
	input  wire logic     tx_in,             // transmit input from controller pin
	output logic          rx_out,            // receive output to controller
	input  wire logic     bus_in,            // bus line level from comparator
	output logic          bus_out,           // bus drive level, always low when enabled
	output logic          bus_oe,            // high while pulling the bus dominant
	input  wire logic     cfg_wr,            // one-cycle write strobe of config register
	input  wire lkt_cfg_t cfg_wdata,         // written config value
	output lkt_cfg_t      cfg_rdata,         // readback of config register
	input  wire logic     diag_clr,          // one-cycle clear of the overtemp flag
	output logic          bus_overtemp_flag, // sticky overtemperature diagnosis
	input  wire logic     overtemp,          // thermal sensor level, async
	input  wire logic     supply_ok,         // supply in operating range, async
	output lkt_drv_t      drv_ctrl,          // analog stage controls
	output logic          tx_timeout         // transmit blocked by time-out
);

	// synchronisers: first stage is read only by the second
	logic [2:0] sync1;
	logic [2:0] sync2;
	logic [2:0] next_sync1;
	logic [2:0] next_sync2;
	logic       bus_s2;
	logic       bus_s1;
	logic       next_bus_s1;
	logic       next_bus_s2;
	logic       tx_prev;      // previous synced transmit level
	logic       next_tx_prev;

	// synced levels, named for reading
	logic tx_s;
	logic ot_s;
	logic sup_s;
	assign tx_s  = sync2[0];
	assign ot_s  = sync2[1];
	assign sup_s = sync2[2];

	// edge detection on the synced transmit input
	logic tx_fall;
	logic tx_rise;
	assign tx_fall = tx_prev & ~tx_s;
	assign tx_rise = ~tx_prev & tx_s;

	// input sampling next values
	always_comb
	begin
		next_sync1   = {supply_ok, overtemp, tx_in};
		next_sync2   = sync1;
		next_bus_s1  = bus_in;
		next_bus_s2  = bus_s1;
		next_tx_prev = tx_s;
	end

	// input sampling registers; reset to recessive, supply good, cool
	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			sync1   <= 3'h5;
			sync2   <= 3'h5;
			bus_s1  <= 1'b1;
			bus_s2  <= 1'b1;
			tx_prev <= 1'b1;
		end
		else
		begin
			sync1   <= next_sync1;
			sync2   <= next_sync2;
			bus_s1  <= next_bus_s1;
			bus_s2  <= next_bus_s2;
			tx_prev <= next_tx_prev;
		end
	end

	// configuration register: mode and time-out enable
	lkt_cfg_t cfg;
	lkt_cfg_t next_cfg;

	// overtemperature leaves the config untouched, only writes change it
	always_comb
	begin
		next_cfg = cfg;
		if (cfg_wr)
		begin
			next_cfg = cfg_wdata;
			// unused encoding falls back to normal so the bus is never stuck
			if (cfg_wdata.mode != LKT_MODE_NORMAL && cfg_wdata.mode != LKT_MODE_RX_ONLY
				&& cfg_wdata.mode != LKT_MODE_FLASH)
			begin
				next_cfg.mode = LKT_MODE_NORMAL;
			end
		end
	end

	// config register; reset value fixes the power-on mode
	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			cfg.mode              <= lkt_mode_t'(`LKT_MODE_RST);
			cfg.tx_timeout_enable <= `LKT_TOE_RST;
		end
		else
		begin
			cfg <= next_cfg;
		end
	end

	// dominant time-out supervisor
	lkt_to_state_t             to_state;
	lkt_to_state_t             next_to_state;
	logic [`LKT_TO_CNT_W-1:0]  to_cnt;
	logic [`LKT_TO_CNT_W-1:0]  next_to_cnt;
	localparam logic [`LKT_TO_CNT_W-1:0] TO_LAST = `LKT_TO_CNT_W'(`LKT_TO_CYCLES - 1);

	// count dominant run; block until a rising edge
	always_comb
	begin
		next_to_state = to_state;
		next_to_cnt   = to_cnt;
		case (to_state)
			LKT_TO_IDLE:
			begin
				next_to_cnt = '0;
				if (tx_fall && cfg.tx_timeout_enable)
				begin
					next_to_state = LKT_TO_RUN;
				end
			end
			LKT_TO_RUN:
			begin
				next_to_cnt = to_cnt + 1'b1;
				if (!cfg.tx_timeout_enable || tx_rise)
				begin
					// disabled or dominant run ended in time
					next_to_state = LKT_TO_IDLE;
					next_to_cnt   = '0;
				end
				else if (to_cnt == TO_LAST)
				begin
					next_to_state = LKT_TO_BLOCKED;
				end
			end
			LKT_TO_BLOCKED:
			begin
				next_to_cnt = '0;
				if (tx_rise || !cfg.tx_timeout_enable)
				begin
					next_to_state = LKT_TO_IDLE;
				end
			end
			default:
			begin
				next_to_state = LKT_TO_IDLE;
				next_to_cnt   = '0;
			end
		endcase
	end

	// time-out registers
	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			to_state <= LKT_TO_IDLE;
			to_cnt   <= '0;
		end
		else
		begin
			to_state <= next_to_state;
			to_cnt   <= next_to_cnt;
		end
	end

	// output stage and diagnosis
	logic     next_bus_oe;
	logic     next_rx_out;
	logic     next_ot_flag;
	logic     next_tx_timeout;
	lkt_drv_t next_drv;
	logic     blocked;
	assign blocked = (next_to_state == LKT_TO_BLOCKED);

	// driver is level based except for the time-out block, so other faults clear by themselves
	always_comb
	begin
		// dominant only when low, normal or flash, cool and not blocked
		next_bus_oe = ~tx_s & (cfg.mode != LKT_MODE_RX_ONLY) & ~ot_s & ~blocked;
		// receiver runs in every mode; recessive reads high under bad supply
		next_rx_out = bus_s2 | (~sup_s & bus_s2);
		// sticky flag, set wins over clear
		next_ot_flag = ot_s | (bus_overtemp_flag & ~diag_clr);
		next_tx_timeout = blocked;
		next_drv.drv_enable = (cfg.mode != LKT_MODE_RX_ONLY) & ~ot_s;
		// flash trades edge shaping for speed
		next_drv.slope_ctrl    = (cfg.mode != LKT_MODE_FLASH);
		next_drv.current_limit = (cfg.mode != LKT_MODE_FLASH);
	end

	// output registers; no wake output exists at all
	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			bus_oe            <= 1'b0;
			rx_out            <= 1'b1;
			bus_overtemp_flag <= 1'b0;
			tx_timeout        <= 1'b0;
			drv_ctrl          <= 3'h7;
			cfg_rdata         <= lkt_cfg_t'({`LKT_TOE_RST, `LKT_MODE_RST});
		end
		else
		begin
			bus_oe            <= next_bus_oe;
			rx_out            <= next_rx_out;
			bus_overtemp_flag <= next_ot_flag;
			tx_timeout        <= next_tx_timeout;
			drv_ctrl          <= next_drv;
			cfg_rdata         <= next_cfg;
		end
	end

	// bus is only ever pulled low
	assign bus_out = 1'b0;

	// checks
	property p_rx_only_quiet;
		@(posedge mclk) disable iff (!nrst) (cfg.mode == LKT_MODE_RX_ONLY) |=> !bus_oe;
	endproperty
	a_rx_only_quiet: assert property (p_rx_only_quiet) else $error("bus driven in receive-only");

	property p_recessive_quiet;
		@(posedge mclk) disable iff (!nrst) tx_s |=> !bus_oe;
	endproperty
	a_recessive_quiet: assert property (p_recessive_quiet) else $error("dominant on recessive input");

	property p_timeout_hit;
		@(posedge mclk) disable iff (!nrst)
			(to_state == LKT_TO_RUN && to_cnt == TO_LAST && !tx_rise && cfg.tx_timeout_enable) |=> tx_timeout && !bus_oe;
	endproperty
	a_timeout_hit: assert property (p_timeout_hit) else $error("time-out did not block");

	property p_rearm;
		@(posedge mclk) disable iff (!nrst) (to_state == LKT_TO_BLOCKED && tx_rise) |=> !tx_timeout;
	endproperty
	a_rearm: assert property (p_rearm) else $error("no re-arm on rising edge");

	property p_toe_off;
		@(posedge mclk) disable iff (!nrst) !cfg.tx_timeout_enable |=> to_state == LKT_TO_IDLE;
	endproperty
	a_toe_off: assert property (p_toe_off) else $error("time-out ran while disabled");

	property p_ot_flag;
		@(posedge mclk) disable iff (!nrst) (ot_s && !cfg_wr) |=> bus_overtemp_flag && !bus_oe && $stable(cfg);
	endproperty
	a_ot_flag: assert property (p_ot_flag) else $error("overtemp handling wrong");

	property p_flash;
		@(posedge mclk) disable iff (!nrst) (cfg.mode == LKT_MODE_FLASH) |=> !drv_ctrl.slope_ctrl && !drv_ctrl.current_limit;
	endproperty
	a_flash: assert property (p_flash) else $error("flash kept slope control");

	property p_normal;
		@(posedge mclk) disable iff (!nrst) (cfg.mode == LKT_MODE_NORMAL) |=> drv_ctrl.slope_ctrl && drv_ctrl.current_limit;
	endproperty
	a_normal: assert property (p_normal) else $error("normal lost slope control");

	property p_rx_follow;
		@(posedge mclk) disable iff (!nrst) 1'b1 |=> rx_out == $past(bus_s2);
	endproperty
	a_rx_follow: assert property (p_rx_follow) else $error("receive output wrong");

	property p_cfg_write;
		@(posedge mclk) disable iff (!nrst) (cfg_wr && cfg_wdata.mode == LKT_MODE_RX_ONLY) |=> cfg.mode == LKT_MODE_RX_ONLY;
	endproperty
	a_cfg_write: assert property (p_cfg_write) else $error("mode write not applied");

	// the spare encoding must land on normal, never leave the bus unusable
	property p_cfg_fallback;
		@(posedge mclk) disable iff (!nrst) (cfg_wr && cfg_wdata.mode == 2'h2) |=> cfg.mode == LKT_MODE_NORMAL;
	endproperty
	a_cfg_fallback: assert property (p_cfg_fallback) else $error("spare mode code not mapped");

	property p_cnt_clear;
		@(posedge mclk) disable iff (!nrst) tx_rise |=> to_cnt == '0;
	endproperty
	a_cnt_clear: assert property (p_cnt_clear) else $error("counter kept after rising edge");

	property p_cnt_start;
		@(posedge mclk) disable iff (!nrst)
			(to_state == LKT_TO_IDLE && tx_fall && cfg.tx_timeout_enable) |=> to_state == LKT_TO_RUN && to_cnt == '0;
	endproperty
	a_cnt_start: assert property (p_cnt_start) else $error("counter not restarted on falling edge");

	// a block may only end on a rising edge or a cleared enable
	property p_hold_block;
		@(posedge mclk) disable iff (!nrst)
			(to_state == LKT_TO_BLOCKED && !tx_rise && cfg.tx_timeout_enable) |=> tx_timeout && !bus_oe;
	endproperty
	a_hold_block: assert property (p_hold_block) else $error("block released without edge");

	property p_blocked_out;
		@(posedge mclk) disable iff (!nrst) (to_state == LKT_TO_BLOCKED) |-> tx_timeout && !bus_oe;
	endproperty
	a_blocked_out: assert property (p_blocked_out) else $error("output stage live while blocked");

	property p_bad_supply_rx;
		@(posedge mclk) disable iff (!nrst) (!sup_s && bus_s2) |=> rx_out;
	endproperty
	a_bad_supply_rx: assert property (p_bad_supply_rx) else $error("receive low on recessive bus");

	property p_ot_drv;
		@(posedge mclk) disable iff (!nrst) ot_s |=> !drv_ctrl.drv_enable;
	endproperty
	a_ot_drv: assert property (p_ot_drv) else $error("driver enabled while hot");

endmodule
`default_nettype wire

// ---- hw/lkt_pkg.sv ----
// types for the single-wire bus transceiver control block
// assumes lkt_cfg.svh is in the include path
`include "lkt_cfg.svh"
package lkt_pkg;
	// operating modes of the comm_config_register mode field
	typedef enum logic [1:0]
	{
		LKT_MODE_NORMAL  = 2'h0,
		LKT_MODE_RX_ONLY = 2'h1,
		LKT_MODE_FLASH   = 2'h3
	} lkt_mode_t;

	// one write of the comm_config_register
	typedef struct packed
	{
		logic      tx_timeout_enable;
		lkt_mode_t mode;
	} lkt_cfg_t;

	// time-out supervisor states, gray along idle-run-blocked
	typedef enum logic [1:0]
	{
		LKT_TO_IDLE    = 2'h0,
		LKT_TO_RUN     = 2'h1,
		LKT_TO_BLOCKED = 2'h3
	} lkt_to_state_t;

	// analog stage controls toward the driver
	typedef struct packed
	{
		logic drv_enable;
		logic slope_ctrl;
		logic current_limit;
	} lkt_drv_t;
endpackage
